/* File: prech_gpio_pkg.sv */
package prech_gpio_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_OUTPUT_VALUES    = 8'h0f;
  localparam logic [7:0] ADDR_PIN_INPUT_LEVELS     = 8'h10;
  localparam logic [7:0] ADDR_INPUT_PRECHARGE_CH01 = 8'h11;
  localparam logic [7:0] ADDR_INPUT_PRECHARGE_CH23 = 8'h12;
  localparam logic [7:0] ADDR_REF_POS_PRECHARGE    = 8'h13;
  localparam logic [7:0] ADDR_REF_NEG_PRECHARGE    = 8'h14;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_OUTPUT_VALUES    = 8'h00;
  localparam logic [7:0] RST_PIN_INPUT_LEVELS     = 8'h00;
  localparam logic [7:0] RST_INPUT_PRECHARGE      = 8'hff;
  localparam logic [7:0] RST_REF_PRECHARGE        = 8'h00;
  localparam logic [7:0] MASK_PIN_DATA            = 8'h1f;
  localparam logic [7:0] MASK_INPUT_PRECHARGE     = 8'hff;
  localparam logic [7:0] MASK_REF_PRECHARGE       = 8'h33;
  localparam logic [7:0] READ_UNMAPPED            = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NUM_PINS          = 5;
  localparam int SYNC_STAGES       = 2;
  localparam int IN_BUF_LO_PLUS    = 0;
  localparam int IN_BUF_LO_MINUS   = 1;
  localparam int IN_BUF_HI_PLUS    = 2;
  localparam int IN_BUF_HI_MINUS   = 3;
  localparam int VREF_BUF_C0       = 0;
  localparam int VREF_BUF_C1       = 1;
  localparam int VREF_BUF_C2       = 4;
  localparam int VREF_BUF_C3       = 5;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic       spi_control_mode;
    logic       user_pins_global_on;
    logic [4:0] dir;
  } pin_cfg_t;

  typedef struct packed {
    logic pin4_out_value;
    logic pin3_out_value;
    logic pin2_out_value;
    logic pin1_out_value;
    logic pin0_out_value;
  } pin_out_bits_t;

  typedef struct packed {
    logic pin4_in_level;
    logic pin3_in_level;
    logic pin2_in_level;
    logic pin1_in_level;
    logic pin0_in_level;
  } pin_in_bits_t;

  typedef struct packed {
    logic in_buf_c0_plus_on;
    logic in_buf_c0_minus_on;
    logic in_buf_c1_plus_on;
    logic in_buf_c1_minus_on;
    logic in_buf_c2_plus_on;
    logic in_buf_c2_minus_on;
    logic in_buf_c3_plus_on;
    logic in_buf_c3_minus_on;
    logic vref_plus_buf_c0;
    logic vref_plus_buf_c1;
    logic vref_plus_buf_c2;
    logic vref_plus_buf_c3;
    logic vref_minus_buf_c0;
    logic vref_minus_buf_c1;
    logic vref_minus_buf_c2;
    logic vref_minus_buf_c3;
  } precharge_t;

endpackage

/* File: pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import prech_gpio_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.meta   = async_in;
    // Meta stage feeds only the second stage
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;
endmodule

/* File: byte_reg.sv */
`timescale 1ns/100ps
module byte_reg #(
  parameter logic [7:0] RST_VAL  = 8'h00,
  parameter logic [7:0] WR_MASK  = 8'hff,
  parameter bit         INVERT   = 1'b0
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  // Stored value
  output logic      [7:0] value
);
  import prech_gpio_pkg::*;

  typedef struct packed {
    logic [7:0] value;
  } byte_state_t;

  byte_state_t state_ff;
  byte_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (wr_en) begin
      // Unassigned bits stay zero; inverted registers are masked by WR_MASK too
      nxt_state.value = (INVERT ? ~wdata : wdata) & WR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff.value <= RST_VAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign value = state_ff.value;
endmodule

/* File: prech_gpio_regs.sv */
`timescale 1ns/100ps
module prech_gpio_regs (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  // Register access from the control port
  input  wire prech_gpio_pkg::reg_req_t      reg_req,
  output prech_gpio_pkg::reg_rsp_t           reg_rsp,
  // Pin configuration from the neighbouring enable register
  input  wire prech_gpio_pkg::pin_cfg_t      pin_cfg,
  // General pins
  input  wire logic [4:0]                    pin_in,
  output logic      [4:0]                    pin_out,
  output logic      [4:0]                    pin_oe,
  // Precharge buffer enables
  output prech_gpio_pkg::precharge_t         prech
);
  import prech_gpio_pkg::*;

  // ----------------------------------------------------------------
  // Write and read decode
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input reg_req_t req, input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  function automatic logic rd_hit(input reg_req_t req, input logic [7:0] addr);
    rd_hit = req.rd && (req.addr == addr);
  endfunction

  logic [7:0] out_values;
  logic [7:0] in_prech_ch01;
  logic [7:0] in_prech_ch23;
  logic [7:0] ref_pos;
  logic [7:0] ref_neg;
  logic [4:0] pin_sampled;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  byte_reg #(
    .RST_VAL (RST_PIN_OUTPUT_VALUES),
    .WR_MASK (MASK_PIN_DATA),
    .INVERT  (1'b0)
  ) u_out_values (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_hit(reg_req, ADDR_PIN_OUTPUT_VALUES)),
    .wdata   (reg_req.wdata),
    .value   (out_values)
  );

  byte_reg #(
    .RST_VAL (RST_INPUT_PRECHARGE),
    .WR_MASK (MASK_INPUT_PRECHARGE),
    .INVERT  (1'b1)
  ) u_in_prech_ch01 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_hit(reg_req, ADDR_INPUT_PRECHARGE_CH01)),
    .wdata   (reg_req.wdata),
    .value   (in_prech_ch01)
  );

  byte_reg #(
    .RST_VAL (RST_INPUT_PRECHARGE),
    .WR_MASK (MASK_INPUT_PRECHARGE),
    .INVERT  (1'b1)
  ) u_in_prech_ch23 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_hit(reg_req, ADDR_INPUT_PRECHARGE_CH23)),
    .wdata   (reg_req.wdata),
    .value   (in_prech_ch23)
  );

  byte_reg #(
    .RST_VAL (RST_REF_PRECHARGE),
    .WR_MASK (MASK_REF_PRECHARGE),
    .INVERT  (1'b0)
  ) u_ref_pos (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_hit(reg_req, ADDR_REF_POS_PRECHARGE)),
    .wdata   (reg_req.wdata),
    .value   (ref_pos)
  );

  byte_reg #(
    .RST_VAL (RST_REF_PRECHARGE),
    .WR_MASK (MASK_REF_PRECHARGE),
    .INVERT  (1'b0)
  ) u_ref_neg (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_hit(reg_req, ADDR_REF_NEG_PRECHARGE)),
    .wdata   (reg_req.wdata),
    .value   (ref_neg)
  );

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in (pin_in),
    .sync_out (pin_sampled)
  );

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
    logic [4:0] in_level;
    reg_rsp_t   rsp;
  } top_state_t;

  top_state_t state_ff;
  top_state_t nxt_state;
  logic       pins_active;
  logic [4:0] out_en;

  // Pins are dead outside serial control or with the global enable off
  assign pins_active = pin_cfg.spi_control_mode && pin_cfg.user_pins_global_on;
  assign out_en      = pin_cfg.dir & {NUM_PINS{pins_active}};

  always_comb begin
    nxt_state          = state_ff;
    // Bit n of each data register is pin n
    nxt_state.pin_oe   = out_en;
    nxt_state.pin_out  = out_values[NUM_PINS-1:0] & out_en;
    // Outputs and disabled pins read as zero rather than echoing the pad
    nxt_state.in_level = pin_sampled & ~pin_cfg.dir & {NUM_PINS{pins_active}};
    nxt_state.rsp.rvalid = reg_req.rd;
    nxt_state.rsp.rdata  = READ_UNMAPPED;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_PIN_OUTPUT_VALUES: begin
          nxt_state.rsp.rdata = out_values;
        end
        ADDR_PIN_INPUT_LEVELS: begin
          nxt_state.rsp.rdata = {3'h0, state_ff.in_level};
        end
        ADDR_INPUT_PRECHARGE_CH01: begin
          nxt_state.rsp.rdata = in_prech_ch01;
        end
        ADDR_INPUT_PRECHARGE_CH23: begin
          nxt_state.rsp.rdata = in_prech_ch23;
        end
        ADDR_REF_POS_PRECHARGE: begin
          nxt_state.rsp.rdata = ref_pos;
        end
        ADDR_REF_NEG_PRECHARGE: begin
          nxt_state.rsp.rdata = ref_neg;
        end
        default: begin
          nxt_state.rsp.rdata = READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff.pin_out  <= '0;
      state_ff.pin_oe   <= '0;
      state_ff.in_level <= RST_PIN_INPUT_LEVELS[NUM_PINS-1:0];
      state_ff.rsp      <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rsp = state_ff.rsp;
  assign pin_out = state_ff.pin_out;
  assign pin_oe  = state_ff.pin_oe;

  always_comb begin
    prech                    = '0;
    prech.in_buf_c0_plus_on  = in_prech_ch01[IN_BUF_LO_PLUS];
    prech.in_buf_c0_minus_on = in_prech_ch01[IN_BUF_LO_MINUS];
    prech.in_buf_c1_plus_on  = in_prech_ch01[IN_BUF_HI_PLUS];
    prech.in_buf_c1_minus_on = in_prech_ch01[IN_BUF_HI_MINUS];
    prech.in_buf_c2_plus_on  = in_prech_ch23[IN_BUF_LO_PLUS];
    prech.in_buf_c2_minus_on = in_prech_ch23[IN_BUF_LO_MINUS];
    prech.in_buf_c3_plus_on  = in_prech_ch23[IN_BUF_HI_PLUS];
    prech.in_buf_c3_minus_on = in_prech_ch23[IN_BUF_HI_MINUS];
    prech.vref_plus_buf_c0   = ref_pos[VREF_BUF_C0];
    prech.vref_plus_buf_c1   = ref_pos[VREF_BUF_C1];
    prech.vref_plus_buf_c2   = ref_pos[VREF_BUF_C2];
    prech.vref_plus_buf_c3   = ref_pos[VREF_BUF_C3];
    prech.vref_minus_buf_c0  = ref_neg[VREF_BUF_C0];
    prech.vref_minus_buf_c1  = ref_neg[VREF_BUF_C1];
    prech.vref_minus_buf_c2  = ref_neg[VREF_BUF_C2];
    prech.vref_minus_buf_c3  = ref_neg[VREF_BUF_C3];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Pad and configuration held long enough to cross the synchroniser
  sequence s_pins_settled;
    ($stable(pin_in) && $stable(pin_cfg) && pins_active) [*4];
  endsequence

  sequence s_ch01_inv_write;
    wr_hit(reg_req, ADDR_INPUT_PRECHARGE_CH01) && (reg_req.wdata == 8'h01);
  endsequence

  sequence s_gap_read_ch01;
    !reg_req.wr ##1 rd_hit(reg_req, ADDR_INPUT_PRECHARGE_CH01);
  endsequence

  sequence s_gap_read_out;
    !reg_req.wr ##1 rd_hit(reg_req, ADDR_PIN_OUTPUT_VALUES);
  endsequence

  sequence s_read_levels;
    rd_hit(reg_req, ADDR_PIN_INPUT_LEVELS);
  endsequence

  a_inv_store: assert property (
    wr_hit(reg_req, ADDR_INPUT_PRECHARGE_CH01) |=> (in_prech_ch01 == ~$past(reg_req.wdata))
  ) else $error("input buffer ch01 did not store the inverse");

  a_inv_readback: assert property (
    s_ch01_inv_write ##1 s_gap_read_ch01
      |=> reg_rsp.rvalid && (reg_rsp.rdata == 8'hfe)
  ) else $error("input buffer ch01 readback after 0x01 is not 0xfe");

  // Reset checks must not be switched off by the reset they watch
  a_in_buf_reset: assert property (
    @(posedge sys_clk) disable iff (1'b0)
      srst |=> (in_prech_ch01 == 8'hff) && (in_prech_ch23 == 8'hff) && prech.in_buf_c3_minus_on
  ) else $error("input buffer enables not all on after reset");

  a_ref_reset: assert property (
    @(posedge sys_clk) disable iff (1'b0)
      srst |=> (ref_pos == 8'h00) && (ref_neg == 8'h00) && !prech.vref_plus_buf_c2
  ) else $error("reference buffer enables not off after reset");

  a_reset_outputs: assert property (
    @(posedge sys_clk) disable iff (1'b0)
      srst |=> (pin_out == 5'h00) && (pin_oe == 5'h00) && (out_values == 8'h00)
  ) else $error("pin outputs or output data not cleared by reset");

  a_ref_mask: assert property (
    wr_hit(reg_req, ADDR_REF_POS_PRECHARGE) |=> (ref_pos == ($past(reg_req.wdata) & 8'h33))
      && (prech.vref_plus_buf_c2 == $past(reg_req.wdata[4]))
  ) else $error("positive reference write not masked to bits 0,1,4,5");

  a_refn_map: assert property (
    wr_hit(reg_req, ADDR_REF_NEG_PRECHARGE) |=> (prech.vref_minus_buf_c3 == $past(reg_req.wdata[5]))
      && (prech.vref_minus_buf_c1 == $past(reg_req.wdata[1]))
  ) else $error("negative reference bit mapping wrong");

  a_out_drive: assert property (
    ##1 (pin_out == ($past(out_values[4:0]) & $past(out_en))) && (pin_oe == $past(out_en))
  ) else $error("pin output or enable does not follow its register");

  a_oe_gate: assert property (
    (!pin_cfg.spi_control_mode || !pin_cfg.user_pins_global_on) |=> (pin_oe == 5'h00) && (pin_out == 5'h00)
  ) else $error("pins driven while disabled");

  a_out_readback: assert property (
    wr_hit(reg_req, ADDR_PIN_OUTPUT_VALUES) ##1 s_gap_read_out
      |=> reg_rsp.rvalid && (reg_rsp.rdata == {3'h0, $past(reg_req.wdata[4:0], 3)})
  ) else $error("output data readback wrong");

  a_read_input: assert property (
    s_pins_settled ##0 s_read_levels |=> reg_rsp.rvalid
      && (reg_rsp.rdata == {3'h0, $past(pin_in) & ~$past(pin_cfg.dir)})
  ) else $error("input levels not returned after pins settle");

  a_unmapped_zero: assert property (
    (reg_req.rd && ((reg_req.addr < 8'h0f) || (reg_req.addr > 8'h14))) |=> reg_rsp.rvalid && (reg_rsp.rdata == 8'h00)
  ) else $error("unmapped read not zero");

  a_rvalid_pulse: assert property (
    ##1 (reg_rsp.rvalid == $past(reg_req.rd))
  ) else $error("read answer missing or spurious");

  a_oe_follows: assert property (
    pins_active |=> (pin_oe == $past(pin_cfg.dir))
  ) else $error("pin enables do not follow direction bits");

  a_levels_off: assert property (
    !pins_active |=> (state_ff.in_level == 5'h00)
  ) else $error("input levels not cleared while pins disabled");

endmodule

/* File: gpio_data_and_precharge_enable_regs_bench.sv */
`timescale 1ns/100ps
module gpio_data_and_precharge_enable_regs_bench;
  import prech_gpio_pkg::*;

`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; $display("unexpected %s expected %h seen %h", what, exp, got); end end

  // ----------------------------------------------------------------
  // Clock, reset and stimulus
  // ----------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       srst    = 1'b1;
  reg_req_t   reg_req = '0;
  reg_rsp_t   reg_rsp;
  pin_cfg_t   pin_cfg = '0;
  logic [4:0] pin_in  = 5'h00;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  precharge_t prech;
  int         errors          = 0;
  int         samples_checked = 0;
  logic [7:0] rd_val;
  logic [3:0] refp_bits;
  logic [3:0] refn_bits;

  assign refp_bits = {prech.vref_plus_buf_c0, prech.vref_plus_buf_c1, prech.vref_plus_buf_c2, prech.vref_plus_buf_c3};
  assign refn_bits = {prech.vref_minus_buf_c0, prech.vref_minus_buf_c1, prech.vref_minus_buf_c2, prech.vref_minus_buf_c3};

  always #12.5 sys_clk = ~sys_clk;

  prech_gpio_regs u_prech_gpio_regs (
    .sys_clk (sys_clk),
    .srst    (srst),
    .reg_req (reg_req),
    .reg_rsp (reg_rsp),
    .pin_cfg (pin_cfg),
    .pin_in  (pin_in),
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .prech   (prech)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // Leading idle edge keeps a strobe from being lowered and raised in one step
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    tick(1);
    reg_req.wr    = 1'b1;
    reg_req.addr  = addr;
    reg_req.wdata = data;
    tick(1);
    reg_req.wr    = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    int i;
    tick(1);
    reg_req.rd   = 1'b1;
    reg_req.addr = addr;
    tick(1);
    reg_req.rd   = 1'b0;
    for (i = 0; i < 4; i++) begin
      if (reg_rsp.rvalid === 1'b1) break;
      tick(1);
    end
    if (i == 4) begin
      errors++;
      $display("unexpected rvalid timeout at %h", addr);
      finish_test();
    end
    data = reg_rsp.rdata;
  endtask

  task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp, input string what);
    rd_reg(addr, rd_val);
    `CHK(what, exp, rd_val)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    chk_rd(ADDR_PIN_OUTPUT_VALUES, 8'h00, "out reset");
    chk_rd(ADDR_PIN_INPUT_LEVELS, 8'h00, "in reset");
    chk_rd(ADDR_INPUT_PRECHARGE_CH01, 8'hff, "ch01 reset");
    chk_rd(ADDR_INPUT_PRECHARGE_CH23, 8'hff, "ch23 reset");
    chk_rd(ADDR_REF_POS_PRECHARGE, 8'h00, "refp reset");
    chk_rd(ADDR_REF_NEG_PRECHARGE, 8'h00, "refn reset");
    chk_rd(8'h15, 8'h00, "unmapped read");
    `CHK("prech reset", 16'hff00, 16'(prech))
    `CHK("oe reset", 5'h00, pin_oe)
  endtask

  task automatic input_buffers();
    wr_reg(ADDR_INPUT_PRECHARGE_CH01, 8'h01);
    chk_rd(ADDR_INPUT_PRECHARGE_CH01, 8'hfe, "ch01 inverse");
    `CHK("c0 minus", 1'b1, prech.in_buf_c0_minus_on)
    `CHK("c0 plus", 1'b0, prech.in_buf_c0_plus_on)
    wr_reg(ADDR_INPUT_PRECHARGE_CH23, 8'h0a);
    chk_rd(ADDR_INPUT_PRECHARGE_CH23, 8'hf5, "ch23 inverse");
    `CHK("c2 minus", 1'b0, prech.in_buf_c2_minus_on)
    `CHK("c3 minus", 1'b0, prech.in_buf_c3_minus_on)
    `CHK("c3 plus", 1'b1, prech.in_buf_c3_plus_on)
    `CHK("c1 all", 2'b11, {prech.in_buf_c1_plus_on, prech.in_buf_c1_minus_on})
  endtask

  task automatic ref_buffers();
    wr_reg(ADDR_REF_POS_PRECHARGE, 8'hff);
    chk_rd(ADDR_REF_POS_PRECHARGE, 8'h33, "refp mask");
    `CHK("refp all", 4'hf, refp_bits)
    wr_reg(ADDR_REF_POS_PRECHARGE, 8'h21);
    `CHK("refp c0 c3", 4'h9, refp_bits)
    wr_reg(ADDR_REF_NEG_PRECHARGE, 8'hd2);
    chk_rd(ADDR_REF_NEG_PRECHARGE, 8'h12, "refn mask");
    `CHK("refn c1 c2", 4'h6, refn_bits)
  endtask

  task automatic pin_data();
    pin_cfg = '{spi_control_mode: 1'b1, user_pins_global_on: 1'b1, dir: 5'h15};
    wr_reg(ADDR_PIN_OUTPUT_VALUES, 8'hff);
    chk_rd(ADDR_PIN_OUTPUT_VALUES, 8'h1f, "out mask");
    `CHK("pin oe", 5'h15, pin_oe)
    `CHK("pin out", 5'h15, pin_out)
    wr_reg(ADDR_PIN_OUTPUT_VALUES, 8'h04);
    tick(2);
    `CHK("pin out one", 5'h04, pin_out)
    pin_in = 5'h0a;
    tick(4);
    chk_rd(ADDR_PIN_INPUT_LEVELS, 8'h0a, "in levels");
    // Output pins must not leak into the input levels
    pin_in = 5'h1f;
    tick(4);
    chk_rd(ADDR_PIN_INPUT_LEVELS, 8'h0a, "in out pins");
    pin_in = 5'h10;
    pin_cfg.dir = 5'h0f;
    tick(4);
    chk_rd(ADDR_PIN_INPUT_LEVELS, 8'h10, "in pin4");
    wr_reg(ADDR_PIN_INPUT_LEVELS, 8'h00);
    chk_rd(ADDR_PIN_INPUT_LEVELS, 8'h10, "in read only");
  endtask

  task automatic pins_disabled();
    pin_cfg.user_pins_global_on = 1'b0;
    tick(3);
    `CHK("oe global off", 5'h00, pin_oe)
    `CHK("out global off", 5'h00, pin_out)
    chk_rd(ADDR_PIN_INPUT_LEVELS, 8'h00, "in global off");
    pin_cfg = '{spi_control_mode: 1'b0, user_pins_global_on: 1'b1, dir: 5'h1f};
    tick(3);
    `CHK("oe pin mode", 5'h00, pin_oe)
    pin_cfg.spi_control_mode = 1'b1;
    tick(3);
    `CHK("oe back on", 5'h1f, pin_oe)
    `CHK("out back on", 5'h04, pin_out)
  endtask

  task automatic back_to_back_and_reset();
    tick(1);
    reg_req.wr    = 1'b1;
    reg_req.addr  = ADDR_INPUT_PRECHARGE_CH01;
    reg_req.wdata = 8'hf0;
    tick(1);
    reg_req.addr  = ADDR_REF_NEG_PRECHARGE;
    reg_req.wdata = 8'h01;
    tick(1);
    reg_req.wr    = 1'b0;
    chk_rd(ADDR_INPUT_PRECHARGE_CH01, 8'h0f, "b2b ch01");
    chk_rd(ADDR_REF_NEG_PRECHARGE, 8'h01, "b2b refn");
    // Pin configuration register resets along with the block
    pin_cfg = '0;
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    reset_values();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(3);
    srst = 1'b0;
    reset_values();
    input_buffers();
    ref_buffers();
    pin_data();
    pins_disabled();
    back_to_back_and_reset();
    tick(2);
    finish_test();
  end

endmodule
